/* core/di_routing_cfg.svh */
`ifndef DI_ROUTING_CFG_SVH
`define DI_ROUTING_CFG_SVH

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define N_INPUTS 5
`define SW_COUNT 20

// ----------------------------------------------------------------
// Byte offsets on the register bus
// ----------------------------------------------------------------
`define ROUTE_OFS_BASE 8'h00
`define ROUTE_OFS_STEP 8'h04
`define STATUS_OFS 8'h14

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ROUTE_RST 20'h00000
`define RDATA_RST 32'h00000000

// ----------------------------------------------------------------
// Switch positions: switch n sits at bit n-1, weight 2**(n-1)
// ----------------------------------------------------------------
`define SW_CLR_IND 0
`define SW_CLR_LATCH 1
`define SW_CLR_MEM 2
`define SW_GROUP_SEL 3
`define SW_TIME_SYNC 4
`define SW_EXT_TRIP 5
`define SW_BF_START 6
`define SW_LOCKOUT_SET 7
`define SW_EXT_ARC 8
`define SW_LOCKOUT_RST 9
`define SW_BLOCK_FIRST 10
`define SW_RECLOSE_OFF 15
`define SW_RECLOSE_INH 16
`define SW_POS_OPEN 17
`define SW_POS_CLOSED 18
`define SW_RECLOSE_EXT 19

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define ST_GROUP2_BIT 8

`endif

/* core/di_routing_pkg.sv */
`include "di_routing_cfg.svh"

package di_routing_pkg;

  // Requests sent to the relay functions
  typedef struct packed {
    logic clear_indications;
    logic release_latched;
    logic clear_memorized;
    logic setting_group2;
    logic time_sync_pulse;
    logic external_trip;
    logic breaker_failure_start;
    logic trip_lockout_set;
    logic external_arc;
    logic trip_lockout_reset;
    logic [4:0] stage_block; // Low oc, high oc, low ef, high ef, phase disc.
    logic auto_reclose_inhibit;
    logic reclose_inhibit;
    logic breaker_pos_open;
    logic breaker_pos_closed;
    logic auto_reclose_initiate;
  } fn_req_t;

  // Whole state of the matrix
  typedef struct packed {
    logic [`N_INPUTS-1:0][`SW_COUNT-1:0] route;
    logic [`N_INPUTS-1:0] din_prev;
    logic wreq;
    logic [31:0] rdata;
    fn_req_t fn;
  } matrix_state_t;

endpackage : di_routing_pkg

/* core/digital_input_routing_matrix.sv */
// How it works
// - One switch group per input, in order
// - Switch 1 lets input clear indications
// - Switch 2 clears indications, releases latched contacts
// - Switch 3 also clears memorized values
// - Switch 4 selects setting group two
// - Switch 5 makes input a time-sync pulse
// - Switch 6 raises external trip
// - Switch 7 starts breaker failure protection
// - Switch 8 sets trip lockout
// - Switch 9 signals external arc detection
// - Switch 10 resets trip lockout
// - Switches 11-15 block five protection stages
// - Switch 16 inhibits auto reclose
// - Switch 17 inhibits breaker reclosing
// - Switch 20 initiates auto reclose
// - Group reads back as weight sum checksum
//
// Added by the designer: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`include "di_routing_cfg.svh"

module digital_input_routing_matrix (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [`N_INPUTS-1:0] digital_in,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output di_routing_pkg::fn_req_t fn_req
);
  import di_routing_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  matrix_state_t s_r; // Registered state
  matrix_state_t s_nxt; // Next state
  logic [`N_INPUTS-1:0][`SW_COUNT-1:0] req; // Per-input requests
  logic [`SW_COUNT-1:0] any_req; // Requests merged over inputs
  logic [`N_INPUTS-1:0] grp_sel; // Inputs that steer the group
  logic [`N_INPUTS-1:0] sync_sel; // Inputs used as sync source
  logic [5:0] word_idx; // Word index of the bus address
  logic route_hit; // Address falls on a routing register
  logic [2:0] route_idx; // Which routing register

  // ----------------------------------------------------------------
  // Per-input gating
  // ----------------------------------------------------------------
  // Input i is governed by group i only
  for (genvar i = 0; i < `N_INPUTS; i++) begin : g_slice
    input_route_slice #(
      .W(`SW_COUNT)
    ) u_slice (
      .din(digital_in[i]),
      .switches(s_r.route[i]),
      .req(req[i])
    );
    assign grp_sel[i] = s_r.route[i][`SW_GROUP_SEL];
    assign sync_sel[i] = s_r.route[i][`SW_TIME_SYNC];
  end

  // Merge of all inputs; several switches act at once
  always_comb begin
    any_req = '0;
    for (int i = 0; i < `N_INPUTS; i++) begin
      any_req = any_req | req[i];
    end
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  assign word_idx = avs_address[7:2];
  assign route_hit = (avs_address[1:0] == 2'h0) && (word_idx < 6'(`N_INPUTS));
  assign route_idx = word_idx[2:0];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.din_prev = digital_in;
    // Clearing: each higher switch adds to the lower ones' effect
    s_nxt.fn.clear_indications = any_req[`SW_CLR_IND] |
                                 any_req[`SW_CLR_LATCH] |
                                 any_req[`SW_CLR_MEM];
    s_nxt.fn.release_latched = any_req[`SW_CLR_LATCH] | any_req[`SW_CLR_MEM];
    s_nxt.fn.clear_memorized = any_req[`SW_CLR_MEM];
    // Group held when no input is allowed to steer it
    if (|grp_sel) begin
      s_nxt.fn.setting_group2 = |(grp_sel & digital_in);
    end
    // Sync marks the rising edge only, so a long level is one pulse
    s_nxt.fn.time_sync_pulse = |(sync_sel & digital_in & ~s_r.din_prev);
    s_nxt.fn.external_trip = any_req[`SW_EXT_TRIP];
    s_nxt.fn.breaker_failure_start = any_req[`SW_BF_START];
    s_nxt.fn.trip_lockout_set = any_req[`SW_LOCKOUT_SET];
    s_nxt.fn.external_arc = any_req[`SW_EXT_ARC];
    s_nxt.fn.trip_lockout_reset = any_req[`SW_LOCKOUT_RST];
    s_nxt.fn.stage_block = any_req[`SW_BLOCK_FIRST +: 5];
    s_nxt.fn.auto_reclose_inhibit = any_req[`SW_RECLOSE_OFF];
    s_nxt.fn.reclose_inhibit = any_req[`SW_RECLOSE_INH];
    s_nxt.fn.breaker_pos_open = any_req[`SW_POS_OPEN];
    s_nxt.fn.breaker_pos_closed = any_req[`SW_POS_CLOSED];
    s_nxt.fn.auto_reclose_initiate = any_req[`SW_RECLOSE_EXT];
    // Bus: answer one cycle after the request, commit on release
    if (s_r.wreq) begin
      // First cycle of a request: prepare the answer
      if (avs_read || avs_write) begin
        s_nxt.wreq = 1'b0;
        s_nxt.rdata = `RDATA_RST;
        if (route_hit) begin
          // Plain value is the weight sum of set switches
          s_nxt.rdata[`SW_COUNT-1:0] = s_r.route[route_idx];
        end else if (avs_address == `STATUS_OFS) begin
          s_nxt.rdata[`N_INPUTS-1:0] = digital_in;
          s_nxt.rdata[`ST_GROUP2_BIT] = s_r.fn.setting_group2;
        end
      end
    end else begin
      // Answer cycle: master takes it at this edge
      s_nxt.wreq = 1'b1;
      // Unmapped or misaligned writes are dropped silently
      if (avs_write && route_hit) begin
        for (int b = 0; b < `SW_COUNT; b++) begin
          if (avs_byteenable[b / 8]) begin
            s_nxt.route[route_idx][b] = avs_writedata[b];
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_r.route <= {`N_INPUTS{`ROUTE_RST}};
      // Input already high at release looks like a rising edge, but reset clears switch 5, so no sync pulse follows
      s_r.din_prev <= '0;
      s_r.wreq <= 1'b1;
      s_r.rdata <= `RDATA_RST;
      s_r.fn <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Straight from flops, so no decode glitch reaches trip logic
  assign avs_readdata = s_r.rdata;
  assign avs_waitrequest = s_r.wreq;
  assign fn_req = s_r.fn;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  // Helper: any input whose group holds a given switch
  logic [`N_INPUTS-1:0] col_mem;
  logic [`N_INPUTS-1:0] col_blk_lo;
  for (genvar i = 0; i < `N_INPUTS; i++) begin : g_col
    assign col_mem[i] = s_r.route[i][`SW_CLR_MEM];
    assign col_blk_lo[i] = s_r.route[i][`SW_BLOCK_FIRST];
  end

  // Helper: for each switch, the inputs whose group holds it
  logic [`SW_COUNT-1:0][`N_INPUTS-1:0] col; // Taken from the registers, not the slices
  for (genvar j = 0; j < `SW_COUNT; j++) begin : g_sw
    for (genvar i = 0; i < `N_INPUTS; i++) begin : g_in
      assign col[j][i] = s_r.route[i][j];
    end
  end

  // ----------------------------------------------------------------
  // Function request assertions
  // ----------------------------------------------------------------

  // Any clearing switch on a live input clears indications
  clear_ind_a: assert property (
    ##1 fn_req.clear_indications == $past(|((col[`SW_CLR_IND] | col[`SW_CLR_LATCH]
      | col[`SW_CLR_MEM]) & digital_in)))
    else $error("indication clear does not follow enabled inputs");

  // Release never comes without the indication clear
  release_latch_a: assert property (
    fn_req.release_latched |-> fn_req.clear_indications)
    else $error("latched release without indication clear");

  // Switch 2 or 3 on a live input releases latched contacts
  release_need_a: assert property (
    |((col[`SW_CLR_LATCH] | col[`SW_CLR_MEM]) & digital_in) |=> fn_req.release_latched)
    else $error("latched release missing");

  // Memorized clear carries the two lighter clears along
  clear_mem_a: assert property (
    |(col_mem & digital_in) |=> fn_req.clear_memorized && fn_req.release_latched
      && fn_req.clear_indications)
    else $error("memorized clear incomplete");

  // Steering inputs decide the group every cycle
  group_sel_a: assert property (
    (|grp_sel) |=> fn_req.setting_group2 == $past(|(grp_sel & digital_in)))
    else $error("setting group does not follow the input");

  // No steering input, so the group must not move
  group_hold_a: assert property (
    !(|grp_sel) |=> $stable(fn_req.setting_group2))
    else $error("setting group changed without a steering input");

  // Pulse only in the cycle after an enabled input rises
  sync_pulse_a: assert property (
    fn_req.time_sync_pulse == |($past(sync_sel & digital_in) & ~$past(digital_in, 2)))
    else $error("time sync pulse not tied to a rising input");

  // First stage block at the low end of the field
  stage_block_a: assert property (
    |(col_blk_lo & digital_in) |=> fn_req.stage_block[0])
    else $error("low overcurrent block missing");

  // Phase discontinuity block follows its switch column
  phase_block_a: assert property (
    ##1 fn_req.stage_block[4] == $past(|(col[`SW_BLOCK_FIRST + 4] & digital_in)))
    else $error("phase discontinuity block mismatch");

  // External trip one cycle behind its inputs
  trip_map_a: assert property (
    ##1 fn_req.external_trip == $past(any_req[`SW_EXT_TRIP]))
    else $error("external trip mismatch");

  // Lockout set and reset may both stand; the lockout logic arbitrates
  lockout_a: assert property (
    ##1 fn_req.trip_lockout_reset == $past(any_req[`SW_LOCKOUT_RST])
      && fn_req.trip_lockout_set == $past(any_req[`SW_LOCKOUT_SET]))
    else $error("trip lockout request mismatch");

  // Breaker failure start from the switch column itself
  bf_start_a: assert property (
    ##1 fn_req.breaker_failure_start == $past(|(col[`SW_BF_START] & digital_in)))
    else $error("breaker failure start mismatch");

  // External arc signal from the switch column itself
  ext_arc_a: assert property (
    ##1 fn_req.external_arc == $past(|(col[`SW_EXT_ARC] & digital_in)))
    else $error("external arc mismatch");

  // Whole reclose function inhibit
  reclose_off_a: assert property (
    ##1 fn_req.auto_reclose_inhibit == $past(|(col[`SW_RECLOSE_OFF] & digital_in)))
    else $error("reclose function inhibit mismatch");

  // Breaker reclosing inhibit
  reclose_block_a: assert property (
    ##1 fn_req.reclose_inhibit == $past(|(col[`SW_RECLOSE_INH] & digital_in)))
    else $error("breaker reclosing inhibit mismatch");

  // External reclose initiation
  reclose_start_a: assert property (
    ##1 fn_req.auto_reclose_initiate == $past(|(col[`SW_RECLOSE_EXT] & digital_in)))
    else $error("reclose initiation mismatch");

  // ----------------------------------------------------------------
  // Bus and reset assertions
  // ----------------------------------------------------------------

  // Reset clears every switch and request, kept live during reset
  route_reset_a: assert property (
    disable iff (1'b0) reset |=> s_r.route == '0 && fn_req == '0
      && avs_waitrequest && avs_readdata == 32'h00000000)
    else $error("reset left switches or requests set");

  // Full-lane write lands in the addressed group
  write_land_a: assert property (
    avs_write && !avs_waitrequest && route_hit && (&avs_byteenable[2:0])
      |=> s_r.route[$past(route_idx)] == $past(avs_writedata[`SW_COUNT-1:0]))
    else $error("routing write did not land");

  // Read answer carries the group in the next cycle
  readback_a: assert property (
    s_r.wreq && avs_read && route_hit |=> !avs_waitrequest
      && avs_readdata == {12'h000, $past(s_r.route[route_idx])})
    else $error("routing readback wrong");

  // Answer is a single cycle, then the bus is busy again
  wait_answer_a: assert property (
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");

  // ----------------------------------------------------------------
  // Covers
  // ----------------------------------------------------------------
  write_cover_c: cover property (avs_write && !avs_waitrequest && route_hit);
  group_cover_c: cover property ($rose(fn_req.setting_group2));
  sync_cover_c: cover property (fn_req.time_sync_pulse);
  multi_cover_c: cover property (fn_req.external_trip && fn_req.auto_reclose_inhibit);
  lockout_cover_c: cover property (fn_req.trip_lockout_set && fn_req.trip_lockout_reset);

endmodule : digital_input_routing_matrix

/* core/input_route_slice.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------
// One input gated onto every enabled function
// ----------------------------------------------------------------
module input_route_slice #(
  parameter int W = 20
) (
  input wire logic din,
  input wire logic [W-1:0] switches,
  output logic [W-1:0] req
);

  // Every set switch passes the input level on at once
  assign req = switches & {W{din}};

endmodule : input_route_slice

/* testbench/field_inputs.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Field wiring on the five inputs
// ----------------------------------------------------------------
// Levels are held between commands. Contact bounce is not modelled,
// since the matrix takes levels that are already conditioned.
module field_inputs (
  input wire logic sys_clk,
  input wire logic [4:0] level_cmd,
  output logic [4:0] digital_in
);
  // Contacts change just after an edge, one cycle behind the command
  always_ff @(posedge sys_clk) begin
    digital_in <= level_cmd;
  end
endmodule : field_inputs

/* testbench/tb_top.sv */
`timescale 1ns/1ps
`include "di_routing_cfg.svh"

module tb_top;
  import di_routing_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [4:0] level_cmd = 5'h00; // Commanded field levels
  logic [4:0] digital_in;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  fn_req_t fn_req;
  int err_count = 0;
  int cmp_count = 0;
  logic [31:0] q; // Last read word
  logic [7:0] a; // Routing register of the row
  // Switch number and expected request word; switch 5 pulses, tested alone
  int row_sw [19] = '{1, 2, 3, 4, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15, 16, 17, 18, 19, 20};
  logic [19:0] row_exp [19] = '{20'h80000, 20'hc0000, 20'he0000, 20'h10000, 20'h04000,
    20'h02000, 20'h01000, 20'h00800, 20'h00400, 20'h00020, 20'h00040, 20'h00080,
    20'h00100, 20'h00200, 20'h00010, 20'h00008, 20'h00004, 20'h00002, 20'h00001};

  always #12.5 sys_clk = ~sys_clk;

  field_inputs far (.sys_clk(sys_clk), .level_cmd(level_cmd), .digital_in(digital_in));

  digital_input_routing_matrix dut (.sys_clk(sys_clk), .reset(reset),
    .digital_in(digital_in), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .fn_req(fn_req));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task wrap_up;
    if (err_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up

  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check

  // One Avalon cycle; request held until waitrequest low is sampled
  task bus(input logic wr, input logic [7:0] ad, input logic [31:0] d,
           input logic [3:0] be, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= ad;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    // Waitrequest is sampled at the edge, before the flops update
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) begin
      err_count++;
      wrap_up();
    end else begin
      // Data taken at the answer edge, request released right after it
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
    end
  endtask : bus

  // Levels settle through the field model and the one-cycle latency
  task settle;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask : settle

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    for (int k = 0; k < 5; k++) begin
      bus(1'b0, 8'(k * 4), 32'h0, 4'hf, q);
      check(q, 32'h0);
    end
    check({12'h000, fn_req}, 32'h0);
    // One switch at a time, spread over the five groups
    for (int i = 0; i < 19; i++) begin
      a = 8'((i % 5) * 4);
      bus(1'b1, a, 32'h1 << (row_sw[i] - 1), 4'hf, q);
      bus(1'b0, a, 32'h0, 4'hf, q);
      check(q, 32'h1 << (row_sw[i] - 1));
      @(posedge sys_clk) level_cmd <= ~(5'h01 << (i % 5));
      settle();
      check({12'h000, fn_req}, 32'h0);
      @(posedge sys_clk) level_cmd <= 5'h01 << (i % 5);
      settle();
      check(32'(fn_req), 32'(row_exp[i]));
      @(posedge sys_clk) level_cmd <= 5'h00;
      settle();
      check({12'h000, fn_req}, 32'h0);
      bus(1'b1, a, 32'h0, 4'hf, q);
    end
    // Sync pulse lasts one cycle even with the input held
    bus(1'b1, 8'h08, 32'h10, 4'hf, q);
    @(posedge sys_clk) level_cmd <= 5'h04;
    repeat (2) @(posedge sys_clk);
    #1;
    check({31'h0, fn_req.time_sync_pulse}, 32'h1);
    @(posedge sys_clk);
    #1;
    check({31'h0, fn_req.time_sync_pulse}, 32'h0);
    bus(1'b1, 8'h08, 32'h0, 4'hf, q);
    // Group select on input two only, so both groups agree
    bus(1'b1, 8'h04, 32'h8, 4'hf, q);
    @(posedge sys_clk) level_cmd <= 5'h02;
    settle();
    bus(1'b0, 8'h14, 32'h0, 4'hf, q);
    check(q, 32'h102);
    bus(1'b1, 8'h04, 32'h0, 4'hf, q);
    @(posedge sys_clk) level_cmd <= 5'h00;
    settle();
    check({31'h0, fn_req.setting_group2}, 32'h1);
    // Every switch of one group acting together
    bus(1'b1, 8'h10, 32'hffffffff, 4'hf, q);
    bus(1'b0, 8'h10, 32'h0, 4'hf, q);
    check(q, 32'h000fffff);
    @(posedge sys_clk) level_cmd <= 5'h10;
    settle();
    check({12'h000, fn_req}, 32'h000f7fff);
    bus(1'b1, 8'h10, 32'h0, 4'h1, q);
    bus(1'b0, 8'h10, 32'h0, 4'hf, q);
    check(q, 32'h000fff00);
    // Unmapped and misaligned places
    bus(1'b1, 8'h20, 32'hffffffff, 4'hf, q);
    bus(1'b0, 8'h20, 32'h0, 4'hf, q);
    check(q, 32'h0);
    bus(1'b0, 8'h02, 32'h0, 4'hf, q);
    check(q, 32'h0);
    bus(1'b0, 8'h00, 32'h0, 4'hf, q);
    check(q, 32'h0);
    // Reset in mid-run with an input still high
    @(posedge sys_clk) reset <= 1'b1;
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    #1;
    check({12'h000, fn_req}, 32'h0);
    // First edge after release: input five still high, switches cleared
    @(posedge sys_clk);
    #1;
    check({12'h000, fn_req}, 32'h0);
    bus(1'b0, 8'h10, 32'h0, 4'hf, q);
    check(q, 32'h0);
    wrap_up();
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    wrap_up();
  end
endmodule : tb_top
